/* src/pbc_device.sv */
// Behaviour
// - Multiplier zero behaves as multiplier one
// - Range zero disables PLL, forces crystal
// - Program register: N high, L low
// - Source change holds output three edges each, crystal only with PLL off
// - Selected source divided by two
// - Select refused while power off
// - Power clear refused while select set
// - Power on, then select, separate writes
// - Oscillator enable gates crystal and PLL
// - Lock toggle sets flag; enable gates interrupt
// - Manual mode: enable, flag read zero
// - Control register read clears flag
// - Reset powers PLL; reset, stop clear select
// - Select one VCO, zero crystal
// - Low control bits read ones
// - Auto bandwidth bit read/write, reset clear
// - Lock reads state in auto, else zero
// - Acq bit: status auto, control manual
// - Manual acq value kept during auto
// - Write one, wait, read crystal loss
// - Loss detect only with VCO selected
// - Software writes zero test bits
//
// The AHB-Lite register port and the register offsets were decided locally.
module pbc_device
  import pbc_pkg::*;
(
  pbc_link_if.device link,
  input wire logic crystal_clock,
  input wire logic vco_clock,
  input wire logic vco_locked,
  input wire logic vco_tracking,
  input wire logic osc_enable,
  input wire logic stop_mode,
  output logic base_clock_out,
  output logic lock_interrupt,
  output logic crystal_osc_enable,
  output logic pll_enable,
  output logic [3:0] multiplier_n,
  output logic [3:0] range_l,
  output logic bandwidth_auto,
  output logic acq_track
);
  logic clock;
  logic rst;
  logic [3:0] pins;
  logic xtal_s;
  logic vco_s;
  logic lock_s;
  logic track_s;
  logic xtal_prev;
  logic vco_prev;
  logic lock_prev;
  logic xtal_rise;
  logic vco_rise;
  logic lock_toggle;
  logic lock_irq_enable;
  logic lock_change_flag;
  logic pll_power;
  logic base_clock_select;
  logic auto_bw;
  logic acq_shadow;
  logic crystal_loss;
  logic [7:0] program_bits;
  logic range_zero;
  logic wr_ctl;
  logic wr_bw;
  logic wr_prg;
  logic rd_ctl;
  logic [7:0] next_rdata;
  pbc_switch_t sw_state;
  logic source_vco;
  logic [1:0] xtal_edges;
  logic [1:0] vco_edges;

  assign clock = link.clock;
  assign rst = link.rst;

  // Clocks and analog status come from other domains
  pbc_sync #(.WIDTH(4)) pin_sync (
    .clock(clock),
    .rst(rst),
    .din({crystal_clock, vco_clock, vco_locked, vco_tracking}),
    .dout(pins)
  );
  assign xtal_s = pins[3] & osc_enable;
  assign vco_s = pins[2] & pll_enable;
  assign lock_s = pins[1] & auto_bw;
  assign track_s = pins[0];

  // Edge history of the synchronised inputs
  always_ff @(posedge clock) begin
    if (rst) begin
      xtal_prev <= 1'b0;
      vco_prev <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      xtal_prev <= xtal_s;
      vco_prev <= vco_s;
      lock_prev <= lock_s;
    end
  end
  assign xtal_rise = xtal_s & ~xtal_prev;
  assign vco_rise = vco_s & ~vco_prev;
  assign lock_toggle = lock_s ^ lock_prev;

  assign wr_ctl = link.reg_wr && link.reg_addr == PBC_IDX_CONTROL;
  assign wr_bw = link.reg_wr && link.reg_addr == PBC_IDX_BANDWIDTH;
  assign wr_prg = link.reg_wr && link.reg_addr == PBC_IDX_PROGRAM;
  assign rd_ctl = link.reg_rd && link.reg_addr == PBC_IDX_CONTROL;
  assign range_zero = program_bits[PBC_PRG_L_LSB +: 4] == 4'h0;

  // Power bit; cannot drop while VCO is selected
  always_ff @(posedge clock) begin
    if (rst) begin
      pll_power <= 1'b1;
    end else if (wr_ctl) begin
      pll_power <= link.reg_wdata[PBC_CTL_POWER] | base_clock_select;
    end
  end

  // Select needs the PLL already on and a nonzero range
  always_ff @(posedge clock) begin
    if (rst) begin
      base_clock_select <= 1'b0;
    end else if (stop_mode || range_zero) begin
      base_clock_select <= 1'b0;
    end else if (wr_ctl) begin
      // Old power value: power and select cannot rise together
      base_clock_select <= link.reg_wdata[PBC_CTL_SELECT] & pll_power;
    end
  end

  // Interrupt enable, writable only in automatic mode
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_irq_enable <= 1'b0;
    end else if (!auto_bw) begin
      lock_irq_enable <= 1'b0;
    end else if (wr_ctl) begin
      lock_irq_enable <= link.reg_wdata[PBC_CTL_IRQ_EN];
    end
  end

  // Flag: a toggle in the read cycle wins over the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_change_flag <= 1'b0;
    end else if (!auto_bw) begin
      lock_change_flag <= 1'b0;
    end else if (lock_toggle) begin
      lock_change_flag <= 1'b1;
    end else if (rd_ctl) begin
      lock_change_flag <= 1'b0;
    end
  end

  // Bandwidth mode and manual acquisition shadow
  always_ff @(posedge clock) begin
    if (rst) begin
      auto_bw <= 1'b0;
      acq_shadow <= 1'b0;
    end else if (wr_bw) begin
      auto_bw <= link.reg_wdata[PBC_BW_AUTO];
      if (!auto_bw) begin
        acq_shadow <= link.reg_wdata[PBC_BW_ACQ];
      end
    end
  end

  // Loss detect: software arms, a crystal rising edge disarms
  always_ff @(posedge clock) begin
    if (rst || !base_clock_select) begin
      crystal_loss <= 1'b0;
    end else if (wr_bw && link.reg_wdata[PBC_BW_XLD]) begin
      crystal_loss <= 1'b1;
    end else if (xtal_rise) begin
      crystal_loss <= 1'b0;
    end
  end

  // Programming nibbles locked while the PLL power bit is set
  always_ff @(posedge clock) begin
    if (rst) begin
      program_bits <= PBC_PRG_RESET;
    end else if (wr_prg && !pll_power) begin
      program_bits <= link.reg_wdata;
    end
  end

  // Registered read data, valid the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (link.reg_addr == PBC_IDX_CONTROL) begin
      next_rdata = {lock_irq_enable, lock_change_flag, pll_power,
                    base_clock_select, PBC_CTL_LOW_BITS};
    end else if (link.reg_addr == PBC_IDX_BANDWIDTH) begin
      next_rdata = {auto_bw, lock_s, acq_track,
                    crystal_loss, PBC_BW_TEST_BITS};
    end else if (link.reg_addr == PBC_IDX_PROGRAM) begin
      next_rdata = program_bits;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      link.reg_rdata <= 8'h00;
      link.reg_rvalid <= 1'b0;
    end else begin
      link.reg_rvalid <= link.reg_rd;
      if (link.reg_rd) begin
        link.reg_rdata <= next_rdata;
      end
    end
  end

  // Source switch: hold output until both clocks show edges, or the crystal alone if the PLL is off
  always_ff @(posedge clock) begin
    if (rst) begin
      sw_state <= PBC_SW_RUN;
      source_vco <= 1'b0;
      xtal_edges <= 2'h0;
      vco_edges <= 2'h0;
    end else begin
      case (sw_state)
        PBC_SW_RUN: begin
          xtal_edges <= 2'h0;
          vco_edges <= 2'h0;
          if (base_clock_select != source_vco) begin
            sw_state <= PBC_SW_HOLD;
          end
        end
        PBC_SW_HOLD: begin
          if (xtal_rise && xtal_edges != PBC_SWITCH_EDGES) begin
            xtal_edges <= xtal_edges + 2'h1;
          end
          if (vco_rise && vco_edges != PBC_SWITCH_EDGES) begin
            vco_edges <= vco_edges + 2'h1;
          end
          // Leaving the VCO needs no VCO edges if it has stopped
          if (xtal_edges == PBC_SWITCH_EDGES &&
              (vco_edges == PBC_SWITCH_EDGES || !pll_enable)) begin
            source_vco <= base_clock_select;
            sw_state <= PBC_SW_RUN;
          end
        end
        default: sw_state <= PBC_SW_RUN;
      endcase
    end
  end

  // Toggle per selected rising edge gives 50% duty
  // Sampling at the system clock limits sources to a fraction of it
  always_ff @(posedge clock) begin
    if (rst || stop_mode) begin
      base_clock_out <= 1'b0;
    end else if (sw_state == PBC_SW_RUN &&
                 (source_vco ? vco_rise : xtal_rise)) begin
      base_clock_out <= ~base_clock_out;
    end
  end

  assign lock_interrupt = lock_change_flag & lock_irq_enable
                          & ~stop_mode;
  assign crystal_osc_enable = osc_enable & ~stop_mode;
  assign pll_enable = pll_power & osc_enable & ~range_zero
                      & ~stop_mode;
  assign multiplier_n = (program_bits[PBC_PRG_N_LSB +: 4] == 4'h0) ?
                        4'h1 : program_bits[PBC_PRG_N_LSB +: 4];
  assign range_l = program_bits[PBC_PRG_L_LSB +: 4];
  assign bandwidth_auto = auto_bw;
  assign acq_track = auto_bw ? track_s : acq_shadow;
endmodule

/* inc/pbc_pkg.sv */
package pbc_pkg;
  // Device register indices on the link
  localparam logic [1:0] PBC_IDX_CONTROL = 2'h0;
  localparam logic [1:0] PBC_IDX_BANDWIDTH = 2'h1;
  localparam logic [1:0] PBC_IDX_PROGRAM = 2'h2;
  // Control register fields
  localparam int PBC_CTL_IRQ_EN = 7;
  localparam int PBC_CTL_FLAG = 6;
  localparam int PBC_CTL_POWER = 5;
  localparam int PBC_CTL_SELECT = 4;
  localparam logic [3:0] PBC_CTL_LOW_BITS = 4'hF;
  // Bandwidth register fields
  localparam int PBC_BW_AUTO = 7;
  localparam int PBC_BW_LOCK = 6;
  localparam int PBC_BW_ACQ = 5;
  localparam int PBC_BW_XLD = 4;
  localparam logic [3:0] PBC_BW_TEST_BITS = 4'h0;
  // Programming register fields: N high nibble, L low nibble
  localparam int PBC_PRG_N_LSB = 4;
  localparam int PBC_PRG_L_LSB = 0;
  localparam logic [7:0] PBC_PRG_RESET = 8'h66;
  // Source switch hold: edges of each clock to wait
  localparam logic [1:0] PBC_SWITCH_EDGES = 2'h3;
  // Host AHB-Lite map
  localparam logic [7:0] PBC_AHB_CMD = 8'h00;
  localparam logic [7:0] PBC_AHB_STATUS = 8'h04;
  localparam int PBC_CMD_INDEX_LSB = 8;
  localparam int PBC_CMD_WRITE = 10;
  localparam int PBC_STS_BUSY = 8;
  localparam logic [1:0] PBC_HTRANS_NONSEQ = 2'h2;

  typedef enum {PBC_SW_RUN, PBC_SW_HOLD} pbc_switch_t;
  typedef enum {PBC_H_IDLE, PBC_H_POWER, PBC_H_MAIN, PBC_H_READ} pbc_host_t;
endpackage

/* inc/pbc_link_if.sv */
interface pbc_link_if (
  input wire logic clock,
  input wire logic rst
);
  logic [1:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;

  modport device (
    input clock, rst, reg_addr, reg_wr, reg_rd, reg_wdata,
    output reg_rdata, reg_rvalid
  );
  modport host (
    input clock, rst, reg_rdata, reg_rvalid,
    output reg_addr, reg_wr, reg_rd, reg_wdata
  );
endinterface

/* src/pbc_sync.sv */
module pbc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  initial begin
    if (WIDTH < 1) $error("pbc_sync needs WIDTH of at least 1");
  end

  // Three stages; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a bit only when the second and third stages agree
  always_ff @(posedge clock) begin
    if (rst) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          dout[i] <= stage3[i];
        end
      end
    end
  end
endmodule

/* src/pbc_host.sv */
module pbc_host
  import pbc_pkg::*;
(
  pbc_link_if.host link,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  logic clock;
  logic rst;
  pbc_host_t state;
  logic dp_cmd_write;
  logic cmd_accept;
  logic cmd_write;
  logic [1:0] cmd_index;
  logic [7:0] cmd_data;
  logic [7:0] read_data;
  logic power_shadow;
  logic busy;
  logic split;

  assign clock = link.clock;
  assign rst = link.rst;
  assign busy = state != PBC_H_IDLE;

  // Data phase of a command write; stalls while a command runs
  always_ff @(posedge clock) begin
    if (rst) begin
      dp_cmd_write <= 1'b0;
    end else if (hready) begin
      dp_cmd_write <= hsel && htrans == PBC_HTRANS_NONSEQ && hwrite
                      && haddr == PBC_AHB_CMD;
    end
  end
  assign hreadyout = !(dp_cmd_write && busy);
  assign hresp = 1'b0;
  assign cmd_accept = dp_cmd_write && !busy;

  // Read data registered at the address phase
  always_ff @(posedge clock) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && !hwrite
                 && htrans == PBC_HTRANS_NONSEQ) begin
      hrdata <= 32'h0000_0000;
      if (haddr == PBC_AHB_STATUS) begin
        hrdata <= {23'h00_0000, busy, read_data};
      end
    end
  end

  // Test bits forced to zero on bandwidth writes
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_write <= 1'b0;
      cmd_index <= 2'h0;
      cmd_data <= 8'h00;
    end else if (cmd_accept) begin
      cmd_write <= hwdata[PBC_CMD_WRITE];
      cmd_index <= hwdata[PBC_CMD_INDEX_LSB +: 2];
      cmd_data <= hwdata[7:0];
      if (hwdata[PBC_CMD_INDEX_LSB +: 2] == PBC_IDX_BANDWIDTH) begin
        cmd_data[3:0] <= PBC_BW_TEST_BITS;
      end
    end
  end

  // Power on and select together need a power-only write first
  assign split = cmd_write && cmd_index == PBC_IDX_CONTROL
                 && cmd_data[PBC_CTL_SELECT] && !power_shadow;

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= PBC_H_IDLE;
    end else begin
      case (state)
        PBC_H_IDLE: begin
          if (cmd_accept) begin
            state <= PBC_H_MAIN;
          end
        end
        PBC_H_POWER: state <= PBC_H_MAIN;
        PBC_H_MAIN: begin
          if (split && cmd_data[PBC_CTL_POWER]) begin
            state <= PBC_H_POWER;
          end else if (cmd_write) begin
            state <= PBC_H_IDLE;
          end else begin
            state <= PBC_H_READ;
          end
        end
        PBC_H_READ: begin
          if (link.reg_rvalid) begin
            state <= PBC_H_IDLE;
          end
        end
        default: state <= PBC_H_IDLE;
      endcase
    end
  end

  // Link strobes; one cycle each
  always_ff @(posedge clock) begin
    if (rst) begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_addr <= 2'h0;
      link.reg_wdata <= 8'h00;
    end else begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      if (state == PBC_H_MAIN) begin
        link.reg_addr <= cmd_index;
        if (split && cmd_data[PBC_CTL_POWER]) begin
          link.reg_wr <= 1'b1;
          link.reg_wdata <= cmd_data & ~(8'h01 << PBC_CTL_SELECT);
        end else if (cmd_write) begin
          link.reg_wr <= 1'b1;
          link.reg_wdata <= cmd_data;
        end else begin
          link.reg_rd <= 1'b1;
        end
      end
    end
  end

  // Track power as last written, and read results
  always_ff @(posedge clock) begin
    if (rst) begin
      power_shadow <= 1'b1;
      read_data <= 8'h00;
    end else begin
      if (link.reg_wr && link.reg_addr == PBC_IDX_CONTROL) begin
        power_shadow <= link.reg_wdata[PBC_CTL_POWER] | power_shadow
                        & link.reg_wdata[PBC_CTL_SELECT];
      end
      if (link.reg_rvalid) begin
        read_data <= link.reg_rdata;
      end
    end
  end

  initial begin
    if ($bits(hsize) != 3) $error("pbc_host hsize must be 3 bits");
  end
endmodule

/* verification/pbc_link_properties.sv */
module pbc_link_properties
  import pbc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  logic auto_mode;
  logic sel_maybe;
  logic fresh;
  logic [1:0] rd_idx;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Bandwidth mode as last written
  always_ff @(posedge clock) begin
    if (rst) begin
      auto_mode <= 1'b0;
    end else if (reg_wr && reg_addr == PBC_IDX_BANDWIDTH) begin
      auto_mode <= reg_wdata[PBC_BW_AUTO];
    end
  end

  // Select may be set by any control write; a read settles it
  always_ff @(posedge clock) begin
    if (rst) begin
      sel_maybe <= 1'b0;
      fresh <= 1'b1;
    end else if (reg_wr && reg_addr == PBC_IDX_CONTROL) begin
      sel_maybe <= 1'b1;
      fresh <= 1'b0;
    end else if (reg_rvalid && rd_idx == PBC_IDX_CONTROL) begin
      sel_maybe <= reg_rdata[PBC_CTL_SELECT];
    end
  end

  // Index of the read in flight
  always_ff @(posedge clock) begin
    if (reg_rd) begin
      rd_idx <= reg_addr;
    end
  end

  sequence s_rd(g, idx);
    g && reg_rd && reg_addr == idx ##1 reg_rvalid;
  endsequence

  property p_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("read not answered");
  property p_no_stray;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("answer without read");
  property p_low_ones;
    s_rd(1'b1, PBC_IDX_CONTROL) |-> reg_rdata[3:0] == PBC_CTL_LOW_BITS;
  endproperty
  a_low_ones: assert property (p_low_ones)
    else $error("control low bits not ones");
  property p_sel_power;
    s_rd(1'b1, PBC_IDX_CONTROL)
      |-> !reg_rdata[PBC_CTL_SELECT] || reg_rdata[PBC_CTL_POWER];
  endproperty
  a_sel_power: assert property (p_sel_power)
    else $error("select set with power off");
  property p_reset_ctl;
    s_rd(fresh, PBC_IDX_CONTROL) |-> reg_rdata[5:4] == 2'h2;
  endproperty
  a_reset_ctl: assert property (p_reset_ctl)
    else $error("power or select wrong after reset");
  property p_manual_ctl;
    s_rd(!auto_mode, PBC_IDX_CONTROL) |-> reg_rdata[7:6] == 2'h0;
  endproperty
  a_manual_ctl: assert property (p_manual_ctl)
    else $error("enable or flag nonzero in manual mode");
  property p_manual_lock;
    s_rd(!auto_mode, PBC_IDX_BANDWIDTH) |-> !reg_rdata[PBC_BW_LOCK];
  endproperty
  a_manual_lock: assert property (p_manual_lock)
    else $error("lock nonzero in manual mode");
  property p_xld_sel;
    s_rd(!sel_maybe, PBC_IDX_BANDWIDTH) |-> !reg_rdata[PBC_BW_XLD];
  endproperty
  a_xld_sel: assert property (p_xld_sel)
    else $error("loss detect set with crystal selected");
  property p_test_bits;
    reg_wr && reg_addr == PBC_IDX_BANDWIDTH
      |-> reg_wdata[3:0] == PBC_BW_TEST_BITS;
  endproperty
  a_test_bits: assert property (p_test_bits)
    else $error("bandwidth test bits written nonzero");
  property p_spacing;
    reg_wr || reg_rd |=> !(reg_wr || reg_rd);
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("link strobes back to back");
endmodule

/* verification/pll_base_clock_control_tb.sv */
module pll_base_clock_control_tb
  import pbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int XH = 5;
  localparam int VH = 3;
  localparam logic [1:0] CT = PBC_IDX_CONTROL;
  localparam logic [1:0] BW = PBC_IDX_BANDWIDTH;
  localparam logic [1:0] PG = PBC_IDX_PROGRAM;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic xclk = 1'b0;
  logic vclk = 1'b0;
  logic locked = 1'b0;
  logic track = 1'b0;
  logic osc_en = 1'b1;
  logic stop = 1'b0;
  logic xrun = 1'b1;
  logic bco, irq, xen, pen, bw_auto, acq;
  logic [3:0] mul_n, rng_l;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int xc = 0;
  int vc = 0;

  always #50 clock = ~clock;

  pbc_link_if u_pbc_link_if (.clock(clock), .rst(rst));
  pbc_host u_pbc_host (.link(u_pbc_link_if.host), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(), .hrdata(hrdata));
  pbc_device u_pbc_device (.link(u_pbc_link_if.device),
    .crystal_clock(xclk), .vco_clock(vclk), .vco_locked(locked),
    .vco_tracking(track), .osc_enable(osc_en), .stop_mode(stop),
    .base_clock_out(bco), .lock_interrupt(irq),
    .crystal_osc_enable(xen), .pll_enable(pen), .multiplier_n(mul_n),
    .range_l(rng_l), .bandwidth_auto(bw_auto), .acq_track(acq));
  pbc_link_properties u_pbc_link_properties (.clock(clock), .rst(rst),
    .reg_addr(u_pbc_link_if.reg_addr), .reg_wr(u_pbc_link_if.reg_wr),
    .reg_rd(u_pbc_link_if.reg_rd), .reg_wdata(u_pbc_link_if.reg_wdata),
    .reg_rdata(u_pbc_link_if.reg_rdata),
    .reg_rvalid(u_pbc_link_if.reg_rvalid));

  // Slow source clocks; the crystal can be stopped to fake its loss
  always @(posedge clock) begin
    xc <= (xc + 1) % XH;
    vc <= (vc + 1) % VH;
    if (xrun && xc == 0) xclk <= ~xclk;
    if (vc == 0) vclk <= ~vclk;
  end

  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  function automatic logic [7:0] ctl(input logic ie, f, p, s);
    return {ie, f, p, s, PBC_CTL_LOW_BITS};
  endfunction

  function automatic logic [3:0] eff_n(input logic [3:0] n);
    return (n == 4'h0) ? 4'h1 : n;
  endfunction

  task end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  task w(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One single word transfer; waits on hready in both phases
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= PBC_HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // Device access: command word, then status polled until idle
  task dev(input logic wr, input logic [1:0] i, input logic [7:0] d,
    output logic [7:0] q);
    logic [31:0] s;
    ahb(1'b1, PBC_AHB_CMD, {21'h0, wr, i, d}, s);
    s = 32'h100;
    while (s[PBC_STS_BUSY] !== 1'b0) ahb(1'b0, PBC_AHB_STATUS, 32'h0, s);
    q = s[7:0];
  endtask

  task wr(input logic [1:0] i, input logic [7:0] d);
    logic [7:0] q;
    dev(1'b1, i, d, q);
  endtask

  task rd(input string s, input logic [1:0] i, input logic [7:0] e);
    logic [7:0] q;
    dev(1'b0, i, 8'h00, q);
    chk(s, e, q);
  endtask

  // Skips one edge so a source switch in progress has settled
  task per(input int e);
    longint t0;
    longint t1;
    @(posedge bco);
    @(posedge bco);
    t0 = $time;
    @(negedge bco);
    t1 = $time;
    @(posedge bco);
    chk("period", 8'(e), 8'(($time - t0) / 100));
    chk("high", 8'(e / 2), 8'((t1 - t0) / 100));
    @(posedge clock);
  endtask

  initial begin
    logic [7:0] v;
    void'($urandom(32'h1f7303b6));
    w(16);
    rst <= 1'b0;
    w(1);
    rd("ctl", CT, ctl(0, 0, 1, 0));
    rd("bw", BW, 8'h00);
    rd("prg", PG, PBC_PRG_RESET);
    wr(PG, 8'h12);
    rd("prg", PG, PBC_PRG_RESET);
    wr(CT, ctl(0, 0, 0, 0));
    wr(CT, ctl(0, 0, 0, 1));
    rd("ctl", CT, ctl(0, 0, 0, 0));
    // Corner values then random ones
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'h05 : (k == 1) ? 8'h1F : 8'($urandom);
      wr(PG, v);
      rd("prg", PG, v);
      chk("mul", {4'h0, eff_n(v[7:4])}, {4'h0, mul_n});
      chk("rng", {4'h0, v[3:0]}, {4'h0, rng_l});
    end
    wr(PG, 8'h30);
    wr(CT, ctl(0, 0, 1, 1));
    rd("ctl", CT, ctl(0, 0, 1, 0));
    chk("pen", 8'h00, {7'h0, pen});
    wr(CT, ctl(0, 0, 0, 0));
    wr(PG, 8'h36);
    wr(CT, ctl(0, 0, 1, 1));
    rd("ctl", CT, ctl(0, 0, 1, 1));
    per(4 * VH);
    wr(CT, ctl(0, 0, 0, 1));
    rd("ctl", CT, ctl(0, 0, 1, 1));
    // Automatic mode: lock toggles, interrupt, flag
    wr(BW, 8'h80);
    chk("auto", 8'h01, {7'h0, bw_auto});
    wr(CT, ctl(1, 0, 1, 1));
    locked <= 1'b1;
    track <= 1'b1;
    w(8);
    chk("irq", 8'h01, {7'h0, irq});
    rd("bw", BW, 8'hE0);
    rd("ctl", CT, ctl(1, 1, 1, 1));
    rd("ctl", CT, ctl(1, 0, 1, 1));
    chk("irq", 8'h00, {7'h0, irq});
    wr(CT, ctl(0, 0, 1, 1));
    locked <= 1'b0;
    track <= 1'b0;
    w(8);
    chk("irq", 8'h00, {7'h0, irq});
    rd("ctl", CT, ctl(0, 1, 1, 1));
    locked <= 1'b1;
    w(8);
    wr(BW, 8'h00);
    rd("ctl", CT, ctl(0, 0, 1, 1));
    wr(CT, ctl(1, 0, 1, 1));
    rd("ctl", CT, ctl(0, 0, 1, 1));
    wr(BW, 8'h20);
    rd("bw", BW, 8'h20);
    chk("acq", 8'h01, {7'h0, acq});
    wr(BW, 8'hA0);
    w(8);
    chk("acq", 8'h00, {7'h0, acq});
    // Crystal loss detect, stopped then running crystal
    // Let a crystal edge still in the synchroniser pass before arming
    xrun <= 1'b0;
    w(8);
    wr(BW, 8'h10);
    w(40);
    // Manual again: the acquisition value written earlier comes back
    rd("bw", BW, 8'h30);
    xrun <= 1'b1;
    wr(BW, 8'h10);
    w(40);
    rd("bw", BW, 8'h00);
    wr(CT, ctl(0, 0, 1, 0));
    per(4 * XH);
    xrun <= 1'b0;
    wr(BW, 8'h10);
    w(40);
    rd("bw", BW, 8'h00);
    xrun <= 1'b1;
    // Stop mode and oscillator enable
    wr(CT, ctl(0, 0, 1, 1));
    stop <= 1'b1;
    w(4);
    chk("stop", 8'h00, {6'h0, bco, irq});
    stop <= 1'b0;
    w(4);
    rd("ctl", CT, ctl(0, 0, 1, 0));
    osc_en <= 1'b0;
    w(4);
    chk("osc", 8'h00, {6'h0, xen, pen});
    osc_en <= 1'b1;
    w(4);
    chk("osc", 8'h03, {6'h0, xen, pen});
    end_sim();
  end
endmodule
